// [rtl/gpio_output_pkg.sv]
package gpio_output_pkg;

    // pin count and register width
    localparam int PIN_COUNT = 7;
    localparam int REG_WIDTH = 8;
    localparam int FC_GPIO_COUNT = 4;

    // register offsets
    localparam logic [7:0] PIN_LEVEL_STATUS_ADDR = 8'h0E;
    localparam logic [7:0] INPUT_ENABLE_CONTROL_ADDR = 8'h0F;
    localparam logic [7:0] PIN_OUTPUT_CONTROL_BASE = 8'h10;
    localparam logic [7:0] PIN_OUTPUT_CONTROL_LAST = 8'h16;
    localparam logic [7:0] PULLDOWN_CONTROL_ADDR = 8'hBE;

    // pin control field positions
    localparam int ENABLE_BIT = 0;
    localparam int VALUE_BIT = 1;
    localparam int SOURCE_LSB = 2;
    localparam int SOURCE_MSB = 4;
    localparam int FUNCTION_LSB = 5;
    localparam int FUNCTION_MSB = 7;

    // values after reset
    localparam logic [7:0] PIN_OUTPUT_CONTROL_RESET = 8'h00;
    localparam logic [7:0] INPUT_ENABLE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PULLDOWN_CONTROL_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

    // open-drain pin index
    localparam int OPEN_DRAIN_PIN = 3;

    // source and function codes
    localparam logic [2:0] SOURCE_RX_PORT0 = 3'h0;
    localparam logic [2:0] SOURCE_RX_PORT1 = 3'h1;
    localparam logic [2:0] FUNC_FC_GPIO3 = 3'h3;
    localparam logic [2:0] FUNC_LOCK = 3'h4;
    localparam logic [2:0] FUNC_PASS = 3'h5;
    localparam logic [2:0] FUNC_FRAME_VALID = 3'h6;
    localparam logic [2:0] FUNC_LINE_VALID = 3'h7;

endpackage

// [rtl/gpio_source_select.sv]
`timescale 1ns/1ps

module gpio_source_select (
    // pin control
    input wire logic [7:0] pinControl,
    // receive port signals
    input wire logic [3:0] fcGpioPort0,
    input wire logic [3:0] fcGpioPort1,
    input wire logic [1:0] rxLock,
    input wire logic [1:0] rxPass,
    input wire logic [1:0] rxFrameValid,
    input wire logic [1:0] rxLineValid,
    // selected level
    output logic driveLevel
);

    logic [2:0] sourceSel;
    logic [2:0] functionSel;
    logic portIndex;
    logic [7:0] portSignals;

    assign sourceSel = pinControl[gpio_output_pkg::SOURCE_MSB:gpio_output_pkg::SOURCE_LSB];
    assign functionSel = pinControl[gpio_output_pkg::FUNCTION_MSB:gpio_output_pkg::FUNCTION_LSB];
    assign portIndex = (sourceSel == gpio_output_pkg::SOURCE_RX_PORT1);

    always_comb begin
        if (portIndex) begin
            portSignals = {rxLineValid[1], rxFrameValid[1], rxPass[1], rxLock[1], fcGpioPort1};
        end else begin
            portSignals = {rxLineValid[0], rxFrameValid[0], rxPass[0], rxLock[0], fcGpioPort0};
        end
    end

    // source picks the port group, function picks one signal in it
    always_comb begin
        if (sourceSel == gpio_output_pkg::SOURCE_RX_PORT0 ||
            sourceSel == gpio_output_pkg::SOURCE_RX_PORT1) begin
            driveLevel = portSignals[functionSel];
        end else begin
            driveLevel = pinControl[gpio_output_pkg::VALUE_BIT];
        end
    end

endmodule

// [rtl/gpio_output_source_mux.sv]
`timescale 1ns/1ps

module gpio_output_source_mux #(
    parameter int PINS = 7
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // receive port signals
    input wire logic [3:0] fcGpioPort0,
    input wire logic [3:0] fcGpioPort1,
    input wire logic [1:0] rxLock,
    input wire logic [1:0] rxPass,
    input wire logic [1:0] rxFrameValid,
    input wire logic [1:0] rxLineValid,
    // gpio pins
    input wire logic [PINS-1:0] pinIn,
    output logic [PINS-1:0] pinOut,
    output logic [PINS-1:0] pinOe,
    output logic [PINS-1:0] pinInputEnable,
    output logic [PINS-1:0] pinPulldownEnable
);

    logic [7:0] controlReg [PINS];
    logic [7:0] inputDisableReg;
    logic [7:0] pulldownDisableReg;
    logic [PINS-1:0] pinMeta;
    logic [PINS-1:0] pinSync;
    logic [PINS-1:0] driveLevel;
    logic [PINS-1:0] pinOut_next;
    logic [PINS-1:0] pinOe_next;
    logic [7:0] readData_next;

    function automatic logic isControlAddr(input logic [7:0] addr);
        return addr >= gpio_output_pkg::PIN_OUTPUT_CONTROL_BASE &&
               addr <= gpio_output_pkg::PIN_OUTPUT_CONTROL_LAST;
    endfunction

    function automatic logic [2:0] controlIndex(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - gpio_output_pkg::PIN_OUTPUT_CONTROL_BASE;
        return diff[2:0];
    endfunction

    // pin level synchroniser
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= pinIn;
            pinSync <= pinMeta;
        end
    end

    // pin control registers
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_ctl
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    controlReg[gi] <= gpio_output_pkg::PIN_OUTPUT_CONTROL_RESET;
                end else if (regWrite && isControlAddr(regAddr) &&
                             controlIndex(regAddr) == 3'(gi)) begin
                    controlReg[gi] <= regWrData;
                end
            end
        end
    endgenerate

    // input enable control register, bit set disables the input path
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            inputDisableReg <= gpio_output_pkg::INPUT_ENABLE_CONTROL_RESET;
        end else if (regWrite && regAddr == gpio_output_pkg::INPUT_ENABLE_CONTROL_ADDR) begin
            inputDisableReg <= regWrData;
        end
    end

    // pulldown control register, bit set disables the pulldown
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pulldownDisableReg <= gpio_output_pkg::PULLDOWN_CONTROL_RESET;
        end else if (regWrite && regAddr == gpio_output_pkg::PULLDOWN_CONTROL_ADDR) begin
            pulldownDisableReg <= regWrData;
        end
    end

    // per-pin source selection
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_sel
            gpio_source_select u_select (
                .pinControl(controlReg[gi]),
                .fcGpioPort0(fcGpioPort0),
                .fcGpioPort1(fcGpioPort1),
                .rxLock(rxLock),
                .rxPass(rxPass),
                .rxFrameValid(rxFrameValid),
                .rxLineValid(rxLineValid),
                .driveLevel(driveLevel[gi])
            );
        end
    endgenerate

    // pin drivers; the open-drain pin only ever pulls low
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (i == gpio_output_pkg::OPEN_DRAIN_PIN) begin
                pinOut_next[i] = 1'b0;
                pinOe_next[i] = controlReg[i][gpio_output_pkg::ENABLE_BIT] && !driveLevel[i];
            end else begin
                pinOut_next[i] = driveLevel[i];
                pinOe_next[i] = controlReg[i][gpio_output_pkg::ENABLE_BIT];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinOut <= '0;
            pinOe <= '0;
        end else begin
            pinOut <= pinOut_next;
            pinOe <= pinOe_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinInputEnable <= '1;
            pinPulldownEnable <= '1;
        end else begin
            pinInputEnable <= ~inputDisableReg[PINS-1:0];
            pinPulldownEnable <= ~pulldownDisableReg[PINS-1:0];
        end
    end

    // register read
    always_comb begin
        readData_next = gpio_output_pkg::READ_IDLE_VALUE;
        if (regAddr == gpio_output_pkg::PIN_LEVEL_STATUS_ADDR) begin
            readData_next = 8'(pinSync);
        end else if (regAddr == gpio_output_pkg::INPUT_ENABLE_CONTROL_ADDR) begin
            readData_next = inputDisableReg;
        end else if (regAddr == gpio_output_pkg::PULLDOWN_CONTROL_ADDR) begin
            readData_next = pulldownDisableReg;
        end else if (isControlAddr(regAddr)) begin
            readData_next = controlReg[controlIndex(regAddr)];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= gpio_output_pkg::READ_IDLE_VALUE;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRead;
            if (regRead) begin
                regRdData <= readData_next;
            end
        end
    end

    // checks
    chk_enable_drives_pin: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[0][0] |=> pinOe[0])
        else $error("pin 0 not driven while enabled");

    chk_disabled_undriven: assert property (@(posedge clock) disable iff (!rst_n)
        !controlReg[1][0] |=> !pinOe[1])
        else $error("pin 1 driven while disabled");

    chk_control_write: assert property (@(posedge clock) disable iff (!rst_n)
        regWrite && regAddr == 8'h12 |=> controlReg[2] == $past(regWrData))
        else $error("control write not stored");

    chk_port0_forward: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[0] == 8'h61 |=> pinOut[0] == $past(fcGpioPort0[3]))
        else $error("pin 0 not following port 0 forward gpio 3");

    chk_port0_lock: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[2] == 8'h83 |=> pinOut[2] == $past(rxLock[0]))
        else $error("pin 2 not following port 0 lock");

    chk_port0_frame: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[4] == 8'hC1 |=> pinOut[4] == $past(rxFrameValid[0]))
        else $error("pin 4 not following port 0 frame valid");

    chk_port1_forward: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[5] == 8'h25 |=> pinOut[5] == $past(fcGpioPort1[1]))
        else $error("pin 5 not following port 1 forward gpio 1");

    chk_port1_pass: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[6] == 8'hA7 |=> pinOut[6] == $past(rxPass[1]))
        else $error("pin 6 not following port 1 pass");

    chk_port1_line: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[1] == 8'hE5 |=> pinOut[1] == $past(rxLineValid[1]))
        else $error("pin 1 not following port 1 line valid");

    chk_status_read: assert property (@(posedge clock) disable iff (!rst_n)
        regRead && regAddr == 8'h0E |=> regRdValid && regRdData == {1'b0, $past(pinSync)})
        else $error("status read does not show pin levels");

    chk_inputs_after_reset: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> pinOe == '0 && pinInputEnable == '1 && pinPulldownEnable == '1)
        else $error("pins not inputs after reset");

    chk_port0_gpio0: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[0] == 8'h01 |=> pinOut[0] == $past(fcGpioPort0[0]))
        else $error("pin 0 not following port 0 forward gpio 0");

    chk_port0_gpio2: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[0] == 8'h41 |=> pinOut[0] == $past(fcGpioPort0[2]))
        else $error("pin 0 not following port 0 forward gpio 2");

    chk_port0_pass: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[0] == 8'hA1 |=> pinOut[0] == $past(rxPass[0]))
        else $error("pin 0 not following port 0 pass");

    chk_port0_line: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[0] == 8'hE1 |=> pinOut[0] == $past(rxLineValid[0]))
        else $error("pin 0 not following port 0 line valid");

    chk_port1_gpio0: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[0] == 8'h05 |=> pinOut[0] == $past(fcGpioPort1[0]))
        else $error("pin 0 not following port 1 forward gpio 0");

    chk_port1_gpio3: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[0] == 8'h67 |=> pinOut[0] == $past(fcGpioPort1[3]))
        else $error("pin 0 not following port 1 forward gpio 3");

    chk_port1_lock: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[0] == 8'h85 |=> pinOut[0] == $past(rxLock[1]))
        else $error("pin 0 not following port 1 lock");

    chk_port1_frame: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[0] == 8'hC5 |=> pinOut[0] == $past(rxFrameValid[1]))
        else $error("pin 0 not following port 1 frame valid");

    chk_value_ignored: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[0] == 8'h03 && !fcGpioPort0[0] |=> !pinOut[0])
        else $error("pin 0 shows the value bit instead of its source");

    chk_od_released: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[3] == 8'h81 && rxLock[0] |=> !pinOe[3])
        else $error("open-drain pin held low while source is high");

    chk_od_driven_low: assert property (@(posedge clock) disable iff (!rst_n)
        controlReg[3] == 8'h81 && !rxLock[0] |=> pinOe[3] && !pinOut[3])
        else $error("open-drain pin not pulled low while source is low");

    chk_pin0_released: assert property (@(posedge clock) disable iff (!rst_n)
        !controlReg[0][0] |=> !pinOe[0])
        else $error("pin 0 driven while disabled");

    chk_ctrl_read: assert property (@(posedge clock) disable iff (!rst_n)
        regRead && regAddr == 8'h13 |=> regRdData == $past(controlReg[3]))
        else $error("control register 3 read back wrong");

    chk_unmapped_write: assert property (@(posedge clock) disable iff (!rst_n)
        regWrite && regAddr == 8'h17 |=> controlReg[6] == $past(controlReg[6]))
        else $error("write past the control block changed a register");

    chk_read_unmapped: assert property (@(posedge clock) disable iff (!rst_n)
        regRead && regAddr == 8'h20 |=> regRdData == 8'h00)
        else $error("unmapped read not zero");

    chk_rdvalid_follows: assert property (@(posedge clock) disable iff (!rst_n)
        regRead |=> regRdValid)
        else $error("read not answered in the next cycle");

    chk_rdvalid_pulse: assert property (@(posedge clock) disable iff (!rst_n)
        !regRead |=> !regRdValid)
        else $error("read valid without a read");

    chk_input_enable: assert property (@(posedge clock) disable iff (!rst_n)
        regWrite && regAddr == 8'h0F |=> ##1 pinInputEnable == ~$past(regWrData[6:0], 2))
        else $error("input enables do not follow their register");

    chk_pulldown_reg: assert property (@(posedge clock) disable iff (!rst_n)
        regWrite && regAddr == 8'hBE |=> ##1 pinPulldownEnable == ~$past(regWrData[6:0], 2))
        else $error("pulldown enables do not follow their register");

endmodule

// [test/board_pins.sv]
`timescale 1ns/1ps

module board_pins (
    // design side
    input wire logic [6:0] pinOut,
    input wire logic [6:0] pinOe,
    input wire logic [6:0] pinPulldownEnable,
    // board stimulus
    input wire logic boardEn,
    input wire logic [6:0] boardDrive,
    // pad level seen by the device
    output logic [6:0] pinIn
);
    // a pin the device leaves undriven is taken by the board while boardEn is set, else reads low with its pulldown enabled and high with it disabled
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (pinOe[i]) begin
                pinIn[i] = pinOut[i];
            end else if (boardEn) begin
                pinIn[i] = boardDrive[i];
            end else begin
                pinIn[i] = !pinPulldownEnable[i];
            end
        end
    end
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin numErrors++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module tb_top;
    logic clock, rst_n, regWrite, regRead, regRdValid, boardEn;
    logic [7:0] regAddr, regWrData, regRdData, rdVal;
    logic [15:0] sigBus;
    logic [6:0] pinIn, pinOut, pinOe, pinInputEnable, pinPulldownEnable, boardDrive;
    int numErrors = 0;
    int nTests = 0;
    int idx;

    gpio_output_source_mux DUT (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .regRdValid(regRdValid), .fcGpioPort0(sigBus[3:0]),
        .fcGpioPort1(sigBus[7:4]), .rxLock(sigBus[9:8]), .rxPass(sigBus[11:10]),
        .rxFrameValid(sigBus[13:12]), .rxLineValid(sigBus[15:14]), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .pinInputEnable(pinInputEnable),
        .pinPulldownEnable(pinPulldownEnable));

    board_pins partner (.pinOut(pinOut), .pinOe(pinOe),
        .pinPulldownEnable(pinPulldownEnable), .boardEn(boardEn),
        .boardDrive(boardDrive), .pinIn(pinIn));

    task automatic summarize();
        $display("errors=%0d checks=%0d", numErrors, nTests);
        if (numErrors == 0 && nTests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(posedge clock);
        #1 regWrite = 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        regAddr = a;
        regRead = 1'b1;
        @(posedge clock);
        #1 regRead = 1'b0;
        for (int i = 0; i < 4 && regRdValid !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        if (regRdValid !== 1'b1) begin
            numErrors++;
            summarize();
        end
        rdVal = regRdData;
        @(posedge clock);
        #1;
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        #200000;
        numErrors++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        sigBus = 16'h0000;
        boardEn = 1'b1;
        boardDrive = 7'h55;
        repeat (10) @(posedge clock);
        #1 rst_n = 1'b1;
        @(posedge clock);
        #1;
        `CHK(pinOe, 7'h00)
        `CHK(pinInputEnable, 7'h7F)
        `CHK(pinPulldownEnable, 7'h7F)
        rd(8'h0F);
        `CHK(rdVal, 8'h00)
        wr(8'h0F, 8'h7F);
        // distinct field values per control register, outputs left off
        for (int i = 0; i < 7; i++) begin
            wr(8'h10 + i[7:0], {i[2:0], i[2:0] ^ 3'h5, 1'b1, 1'b0});
        end
        // writes past the control block and to the status byte are dropped
        wr(8'h17, 8'hFF);
        wr(8'h0E, 8'hFF);
        for (int i = 0; i < 7; i++) begin
            rd(8'h10 + i[7:0]);
            `CHK(rdVal, {i[2:0], i[2:0] ^ 3'h5, 1'b1, 1'b0})
        end
        rd(8'h20);
        `CHK(rdVal, 8'h00)
        `CHK(pinInputEnable, 7'h00)
        // both port sources and every function on pin 0, value bit opposite
        for (int p = 0; p < 2; p++) begin
            for (int f = 0; f < 8; f++) begin
                for (int v = 0; v < 2; v++) begin
                    idx = (f < 4) ? p * 4 + f : 8 + (f - 4) * 2 + p;
                    sigBus = v[0] ? (16'h0001 << idx) : ~(16'h0001 << idx);
                    wr(8'h10, {f[2:0], p[2:0], ~v[0], 1'b1});
                    @(posedge clock);
                    #1;
                    `CHK(pinOut[0], v[0])
                    `CHK(pinOe[0], 1'b1)
                end
            end
        end
        wr(8'h10, 8'h02);
        @(posedge clock);
        #1;
        `CHK(pinOe[0], 1'b0)
        // pins 0 and 3 follow port 0 lock, the board drives the rest
        sigBus = 16'h0100;
        boardDrive = 7'h2A;
        wr(8'h10, 8'h81);
        wr(8'h13, 8'h81);
        repeat (5) @(posedge clock);
        #1;
        rd(8'h0E);
        `CHK(rdVal, 8'h2B)
        // lock low: open-drain pin 3 pulls low against the board
        sigBus = 16'h0000;
        repeat (5) @(posedge clock);
        #1;
        `CHK(pinOe[3], 1'b1)
        rd(8'h0E);
        `CHK(rdVal, 8'h22)
        // board lets go: undriven pins 1, 2 and 4 settle low on their pulldowns, pins 5 and 6 with pulldowns off read high
        boardEn = 1'b0;
        wr(8'hBE, 8'h60);
        repeat (5) @(posedge clock);
        #1;
        `CHK(pinPulldownEnable, 7'h1F)
        rd(8'hBE);
        `CHK(rdVal, 8'h60)
        rd(8'h0E);
        `CHK(rdVal, 8'h60)
        // each remaining pin follows its own port signal
        wr(8'h11, 8'hE5);
        wr(8'h12, 8'h83);
        wr(8'h14, 8'hC1);
        wr(8'h15, 8'h25);
        wr(8'h16, 8'hA7);
        for (int v = 0; v < 2; v++) begin
            sigBus = v[0] ? 16'h9920 : 16'h66DF;
            @(posedge clock);
            #1;
            `CHK(pinOut & 7'h76, v[0] ? 7'h76 : 7'h00)
            `CHK(pinOe & 7'h76, 7'h76)
        end
        summarize();
    end
endmodule
